/* core/usb_in_ep_defs.vh */
// register offsets, field positions and codes for the IN endpoint control
`ifndef USB_IN_EP_DEFS_VH
`define USB_IN_EP_DEFS_VH
// ============================================================
// register offsets
`define ADDR_INDEX 8'h0e
`define ADDR_CTRL_STATUS 8'h11
`define ADDR_CONFIG 8'h12
`define ADDR_IRQ_STATUS 8'h20
`define ADDR_IRQ_CLEAR 8'h21
`define ADDR_IRQ_ENABLE 8'h22
`define ADDR_TOGGLE 8'h23
// ============================================================
// control/status fields
`define CS_PKT_READY 0
`define CS_NOT_EMPTY 1
`define CS_UNDERRUN 2
`define CS_FLUSH 3
`define CS_SEND_STALL 4
`define CS_SENT_STALL 5
`define CS_CLEAR_TOGGLE 6
// ============================================================
// configuration fields
`define CF_SPLIT 2
`define CF_FORCE_TOGGLE 3
`define CF_DIR_SELECT 5
`define CF_ISO 6
`define CF_DOUBLE_BUF 7
`define CF_WRITE_MASK 8'hec
// ============================================================
// handshake and answer codes
`define HS_ACK 2'h0
`define HS_NAK 2'h1
`define HS_NONE 2'h2
`define ANS_DATA 2'h0
`define ANS_ZLP 2'h1
`define ANS_NAK 2'h2
`define ANS_STALL 2'h3
`define RESET_BYTE 8'h00
`endif

/* core/in_packet_slots.v */
// packet slot occupancy for one IN endpoint fifo
module in_packet_slots
(
    input wire clock,
    input wire nrst,
    input wire load,
    input wire drop,
    input wire clear_all,
    input wire double_buf,
    output wire [1:0] count,
    output wire slot_open
);
    reg [1:0] count_q;
    reg [1:0] count_d;

    always @*
    begin
        count_d = count_q;
        if (clear_all)
            count_d = 2'h0;
        else if (load && !drop && count_q != 2'h2)
            count_d = count_q + 2'h1;
        else if (drop && !load && count_q != 2'h0)
            count_d = count_q - 2'h1;
    end

    always @(posedge clock)
    begin
        if (!nrst)
            count_q <= 2'h0;
        else
            count_q <= count_d;
    end

    assign count = count_q;
    // a single-buffered fifo has one slot only
    assign slot_open = double_buf ? (count_q < 2'h2) : (count_q == 2'h0);
endmodule // in_packet_slots

/* core/usb_in_endpoint_control.v */
// IN endpoint 1-3 control, status, toggle and interrupt logic
//
// Decided for this implementation: the plain strobed port.
`include "usb_in_ep_defs.vh"

// Behaviour
// - only the endpoint chosen by the index register is visible in the control, config and toggle registers.
// - split bit set divides the fifo, both IN and OUT pipes usable.
// - unsplit endpoint works one way, direction bit one means IN.
// - interrupt on sent packet, flush of non-empty fifo, or stall.
// - iso bit zero gives bulk/interrupt mode, one gives isochronous mode.
// - bulk IN token with packet ready sends data, clears ready, interrupts.
// - ready set with empty fifo sends a zero-length packet.
// - send-stall in bulk mode answers every IN token with STALL.
// - stall sent sets flag, flushes fifo, clears ready, interrupts.
// - double buffering clears ready when a slot frees, no interrupt.
// - force-toggle flips toggle on every handshake to a sent packet, else only on ACK.
// - clear-toggle write zeroes the data toggle and reads zero.
// - iso token with no packet sends zero-length and sets underrun.
// - bulk NAK sets underrun; flag stays until software clears it.
// - iso update holds new packets and ready reads zero until SOF.
// - flush drops next packet, resets pointer, clears ready, self-clears.
// - fifo-not-empty reads one while a packet is held.
// - unused control bits read zero and ignore writes.
module usb_in_endpoint_control
#(
    parameter NUM_EP = 3
)
(
    input wire clock,
    input wire nrst,
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    input wire rd,
    output reg [7:0] rdata,
    input wire fifo_write,
    input wire isochronous_update,
    input wire sof,
    input wire in_token,
    input wire [1:0] token_ep,
    input wire [1:0] handshake,
    input wire handshake_valid,
    output reg [1:0] answer,
    output reg answer_valid,
    output reg answer_toggle,
    output reg [NUM_EP-1:0] in_enabled,
    output reg [NUM_EP-1:0] out_enabled,
    output reg [NUM_EP-1:0] fifo_split,
    output reg irq
);
    // ============================================================
    // index register and decode
    reg [1:0] index_q;
    wire wr_cs = wr && addr == `ADDR_CTRL_STATUS;
    wire wr_cf = wr && addr == `ADDR_CONFIG;

    function sel;
        input [1:0] idx;
        input integer ep;
        begin
            sel = (idx == ep[1:0] + 2'h1);
        end
    endfunction

    always @(posedge clock)
    begin
        if (!nrst)
            index_q <= 2'h0;
        else if (wr && addr == `ADDR_INDEX)
            index_q <= wdata[1:0];
    end

    // ============================================================
    // per-endpoint state
    reg [NUM_EP-1:0] ready_q;
    reg [NUM_EP-1:0] empty_pkt_q;
    reg [NUM_EP-1:0] has_data_q;
    reg [NUM_EP-1:0] send_stall_q;
    reg [NUM_EP-1:0] sent_stall_q;
    reg [NUM_EP-1:0] underrun_q;
    reg [NUM_EP-1:0] flush_q;
    reg [NUM_EP-1:0] toggle_q;
    reg [NUM_EP-1:0] hold_q;
    reg [NUM_EP-1:0] wait_hs_q;
    reg [NUM_EP-1:0] irq_status_q;
    reg [NUM_EP-1:0] irq_enable_q;
    reg [7:0] cfg_q [0:NUM_EP-1];
    wire [NUM_EP-1:0] ready_rd;
    wire [NUM_EP-1:0] not_empty;
    wire [NUM_EP-1:0] ev_irq;
    wire [NUM_EP-1:0] tok_hit;
    wire [NUM_EP-1:0] any_ans;
    wire [1:0] ans_code [0:NUM_EP-1];

    wire wr_irq_clear = wr && addr == `ADDR_IRQ_CLEAR;

    genvar g;
    generate
        for (g = 0; g < NUM_EP; g = g + 1)
        begin : ep
            wire s = sel(index_q, g);
            wire [7:0] cf = cfg_q[g];
            wire iso = cf[`CF_ISO];
            wire dbl = cf[`CF_DOUBLE_BUF];
            wire is_in = cf[`CF_SPLIT] | cf[`CF_DIR_SELECT];
            wire [1:0] cnt;
            wire open_slot;
            wire w_cs = wr_cs && s;
            wire tok = in_token && sel(token_ep, g) && is_in;
            wire stall_now = tok && !iso && send_stall_q[g];
            // held packets wait for the next sof in iso update mode
            wire avail = (cnt != 2'h0) && !hold_q[g];
            wire send = tok && !stall_now && avail;
            wire zlp_iso = tok && iso && !avail;
            wire nak = tok && !iso && !stall_now && !avail;
            wire loaded = w_cs && wdata[`CS_PKT_READY];
            wire flush_req = w_cs && wdata[`CS_FLUSH];
            wire flush_evt = flush_req && cnt != 2'h0;
            wire hs_done = wait_hs_q[g] && handshake_valid;
            wire flip = hs_done && (cf[`CF_FORCE_TOGGLE] ||
                handshake == `HS_ACK);

            in_packet_slots u_slots
            (
                .clock(clock),
                .nrst(nrst),
                .load(loaded),
                .drop(send | flush_evt),
                .clear_all(stall_now),
                .double_buf(dbl),
                .count(cnt),
                .slot_open(open_slot)
            );

            assign not_empty[g] = cnt != 2'h0;
            assign ready_rd[g] = ready_q[g] &&
                !(iso && isochronous_update && hold_q[g]);
            assign ev_irq[g] = send | flush_evt | stall_now;
            assign tok_hit[g] = tok;
            assign any_ans[g] = stall_now | send | zlp_iso | nak;
            assign ans_code[g] = stall_now ? `ANS_STALL :
                (send && !empty_pkt_q[g]) ? `ANS_DATA :
                (send | zlp_iso) ? `ANS_ZLP : `ANS_NAK;

            always @(posedge clock)
            begin
                if (!nrst)
                begin
                    cfg_q[g] <= `RESET_BYTE;
                    ready_q[g] <= 1'b0;
                    empty_pkt_q[g] <= 1'b0;
                    has_data_q[g] <= 1'b0;
                    send_stall_q[g] <= 1'b0;
                    sent_stall_q[g] <= 1'b0;
                    underrun_q[g] <= 1'b0;
                    flush_q[g] <= 1'b0;
                    toggle_q[g] <= 1'b0;
                    hold_q[g] <= 1'b0;
                    wait_hs_q[g] <= 1'b0;
                    irq_status_q[g] <= 1'b0;
                end
                else
                begin
                    if (wr_cf && s)
                        cfg_q[g] <= wdata & `CF_WRITE_MASK;
                    if (fifo_write && s)
                        has_data_q[g] <= 1'b1;
                    if (loaded)
                    begin
                        empty_pkt_q[g] <= !has_data_q[g] && !fifo_write;
                        has_data_q[g] <= 1'b0;
                        if (iso && isochronous_update)
                            hold_q[g] <= 1'b1;
                    end
                    else if (sof)
                        hold_q[g] <= 1'b0;
                    // ready drops on send, flush, stall, or a free slot
                    if (loaded)
                        ready_q[g] <= !(dbl && cnt == 2'h0);
                    else if (send || flush_evt || stall_now)
                        ready_q[g] <= 1'b0;
                    else if (dbl && ready_q[g] && open_slot)
                        ready_q[g] <= 1'b0;
                    if (w_cs)
                        send_stall_q[g] <= wdata[`CS_SEND_STALL];
                    // hardware set beats a software clear
                    if (stall_now)
                        sent_stall_q[g] <= 1'b1;
                    else if (w_cs && !wdata[`CS_SENT_STALL])
                        sent_stall_q[g] <= 1'b0;
                    if (zlp_iso || nak)
                        underrun_q[g] <= 1'b1;
                    else if (w_cs && !wdata[`CS_UNDERRUN])
                        underrun_q[g] <= 1'b0;
                    // flush finishes in one cycle
                    flush_q[g] <= flush_req;
                    if (send)
                        wait_hs_q[g] <= 1'b1;
                    else if (hs_done)
                        wait_hs_q[g] <= 1'b0;
                    if (w_cs && wdata[`CS_CLEAR_TOGGLE])
                        toggle_q[g] <= 1'b0;
                    else if (flip)
                        toggle_q[g] <= !toggle_q[g];
                    if (ev_irq[g])
                        irq_status_q[g] <= 1'b1;
                    else if (wr_irq_clear && wdata[g])
                        irq_status_q[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // ============================================================
    // register read mux
    reg [7:0] rd_d;
    integer k;
    always @*
    begin
        rd_d = 8'h00;
        for (k = 0; k < NUM_EP; k = k + 1)
        begin
            if (sel(index_q, k) && addr == `ADDR_CTRL_STATUS)
            begin
                rd_d[`CS_PKT_READY] = ready_rd[k];
                rd_d[`CS_NOT_EMPTY] = not_empty[k];
                rd_d[`CS_UNDERRUN] = underrun_q[k];
                rd_d[`CS_FLUSH] = flush_q[k];
                rd_d[`CS_SEND_STALL] = send_stall_q[k];
                rd_d[`CS_SENT_STALL] = sent_stall_q[k];
            end
            if (sel(index_q, k) && addr == `ADDR_CONFIG)
                rd_d = cfg_q[k];
            if (sel(index_q, k) && addr == `ADDR_TOGGLE)
                rd_d[0] = toggle_q[k];
        end
        if (addr == `ADDR_INDEX)
            rd_d[1:0] = index_q;
        if (addr == `ADDR_IRQ_STATUS)
            rd_d[NUM_EP-1:0] = irq_status_q;
        if (addr == `ADDR_IRQ_ENABLE)
            rd_d[NUM_EP-1:0] = irq_enable_q;
    end

    // ============================================================
    // token answer and outputs
    reg [1:0] ans_d;
    reg tog_d;
    reg [NUM_EP-1:0] in_en_d;
    reg [NUM_EP-1:0] out_en_d;
    reg [NUM_EP-1:0] split_d;
    integer j;
    always @*
    begin
        ans_d = `ANS_NAK;
        tog_d = 1'b0;
        for (j = 0; j < NUM_EP; j = j + 1)
        begin
            if (tok_hit[j])
            begin
                ans_d = ans_code[j];
                tog_d = toggle_q[j];
            end
            split_d[j] = cfg_q[j][`CF_SPLIT];
            in_en_d[j] = cfg_q[j][`CF_SPLIT] | cfg_q[j][`CF_DIR_SELECT];
            out_en_d[j] = cfg_q[j][`CF_SPLIT] | !cfg_q[j][`CF_DIR_SELECT];
        end
    end

    always @(posedge clock)
    begin
        if (!nrst)
        begin
            irq_enable_q <= {NUM_EP{1'b0}};
            rdata <= 8'h00;
            answer <= `ANS_NAK;
            answer_valid <= 1'b0;
            answer_toggle <= 1'b0;
            in_enabled <= {NUM_EP{1'b0}};
            out_enabled <= {NUM_EP{1'b0}};
            fifo_split <= {NUM_EP{1'b0}};
            irq <= 1'b0;
        end
        else
        begin
            if (wr && addr == `ADDR_IRQ_ENABLE)
                irq_enable_q <= wdata[NUM_EP-1:0];
            rdata <= rd ? rd_d : 8'h00;
            answer <= ans_d;
            answer_valid <= |any_ans;
            answer_toggle <= tog_d;
            in_enabled <= in_en_d;
            out_enabled <= out_en_d;
            fifo_split <= split_d;
            irq <= |(irq_status_q & irq_enable_q);
        end
    end
endmodule // usb_in_endpoint_control

/* verif/usb_in_ep_monitor.sv */
// concurrent checks on the IN endpoint control ports
`include "usb_in_ep_defs.vh"
module usb_in_ep_monitor
#(
    parameter NUM_EP = 3
)
(
    input wire clock,
    input wire nrst,
    input wire [7:0] addr,
    input wire wr,
    input wire rd,
    input wire [7:0] rdata,
    input wire in_token,
    input wire [1:0] token_ep,
    input wire answer_valid,
    input wire [NUM_EP-1:0] in_enabled,
    input wire [NUM_EP-1:0] out_enabled,
    input wire [NUM_EP-1:0] fifo_split,
    input wire irq
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking dc @(posedge clock); endclocking
    default disable iff (!nrst);
    // ============================================================
    // cycles since the last answer or write, saturating at 7
    reg [2:0] age_q;
    wire [2:0] age_d;
    assign age_d = (answer_valid || wr) ? 3'h0 : age_q + {2'h0, age_q != 3'h7};
    always @(posedge clock)
        age_q <= nrst ? age_d : 3'h7;
    // ============================================================
    // register port and pipe enables
    a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data not zero outside a read");
    a_unmapped_zero: assert property ($past(rd)
        && $past(addr) >= 8'h40 |-> rdata == 8'h00)
        else $error("unmapped read not zero");
    a_ctrl_top_zero: assert property ($past(rd)
        && $past(addr) == `ADDR_CTRL_STATUS |-> rdata[7:6] == 2'h0)
        else $error("control bits 7:6 not zero");
    a_split_both_ways: assert property
        ((fifo_split & ~(in_enabled & out_enabled)) == 0)
        else $error("split endpoint lacks a pipe");
    a_unsplit_one_way: assert property
        ((~fifo_split & in_enabled & out_enabled) == 0)
        else $error("unsplit endpoint open both ways");
    // ============================================================
    // token answers and interrupt
    a_answer_due: assert property (in_token
        && in_enabled[token_ep - 2'h1] |=> answer_valid)
        else $error("no answer to IN token");
    a_no_stray_answer: assert property
        (answer_valid |-> $past(in_token))
        else $error("answer without token");
    a_irq_has_cause: assert property ($rose(irq) |-> age_q < 3'h5)
        else $error("interrupt rose without an event");
endmodule // usb_in_ep_monitor

/* verif/host_model.sv */
// host model issuing IN tokens and handshakes
`include "usb_in_ep_defs.vh"
module host_model
(
    input wire clock,
    output logic in_token,
    output logic [1:0] token_ep,
    output logic [1:0] handshake,
    output logic handshake_valid,
    input wire [1:0] answer,
    input wire answer_valid,
    input wire answer_toggle
);
    timeunit 1ns;
    timeprecision 1ns;
    // toggle that came with the most recent answer
    logic last_toggle = 1'b0;
    initial
    begin
        in_token = 1'b0;
        token_ep = 2'h0;
        handshake = `HS_NONE;
        handshake_valid = 1'b0;
    end
    // one token per call; the task drives no start of frame
    task automatic xfer(input logic [1:0] ep, input logic [1:0] hs,
        output logic [1:0] ans, output logic got);
        got = 1'b0;
        ans = `ANS_NAK;
        @(posedge clock);
        in_token <= 1'b1;
        token_ep <= ep;
        @(posedge clock);
        in_token <= 1'b0;
        // released lines invert so a stale value never looks valid
        token_ep <= ~ep;
        // look mid-cycle, where the registered answer has settled
        repeat (3)
        begin
            @(negedge clock);
            if (answer_valid === 1'b1 && !got)
            begin
                got = 1'b1;
                ans = answer;
                last_toggle = answer_toggle;
            end
        end
        @(posedge clock);
        // a handshake only follows data or a zero-length packet
        if (got && ans <= `ANS_ZLP && hs != `HS_NONE)
        begin
            handshake <= hs;
            handshake_valid <= 1'b1;
            @(posedge clock);
            handshake_valid <= 1'b0;
            handshake <= ~hs;
        end
    endtask
endmodule // host_model

/* verif/tb_usb_in_endpoint_control.sv */
// self-checking testbench for the IN endpoint control block
`include "usb_in_ep_defs.vh"
module tb_usb_in_endpoint_control;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0;
    logic fifo_write = 1'b0, isochronous_update = 1'b0, sof = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00;
    wire [7:0] rdata;
    wire [1:0] token_ep, handshake, answer;
    wire [2:0] in_enabled, out_enabled, fifo_split;
    wire in_token, handshake_valid, answer_valid, answer_toggle, irq;
    int fail_count = 0, total_checks = 0;
    always #50 clock = ~clock;
    usb_in_endpoint_control #(.NUM_EP(3)) dut (.clock(clock), .nrst(nrst),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .fifo_write(fifo_write), .isochronous_update(isochronous_update),
        .sof(sof), .in_token(in_token), .token_ep(token_ep),
        .handshake(handshake), .handshake_valid(handshake_valid),
        .answer(answer), .answer_valid(answer_valid),
        .answer_toggle(answer_toggle), .in_enabled(in_enabled),
        .out_enabled(out_enabled), .fifo_split(fifo_split), .irq(irq));
    host_model host (.clock(clock), .in_token(in_token), .token_ep(token_ep),
        .handshake(handshake), .handshake_valid(handshake_valid),
        .answer(answer), .answer_valid(answer_valid),
        .answer_toggle(answer_toggle));
    // ============================================================
    // shared tasks
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        @(negedge clock);
        chk(rdata, e);
    endtask
    task automatic load(input int n, input logic [7:0] ctl);
        repeat (n)
        begin
            @(posedge clock);
            fifo_write <= 1'b1;
            @(posedge clock);
            fifo_write <= 1'b0;
        end
        wreg(`ADDR_CTRL_STATUS, ctl);
    endtask
    task automatic tok(input logic [1:0] hs, input logic [1:0] e);
        logic [1:0] a;
        logic g;
        host.xfer(2'h1, hs, a, g);
        chk({5'h0, g, a}, {5'h0, 1'b1, e});
    endtask
    // one start of frame between iso tokens
    task automatic frame();
        @(posedge clock);
        sof <= 1'b1;
        @(posedge clock);
        sof <= 1'b0;
    endtask
    // ============================================================
    // scenarios
    task automatic s_config();
        logic [1:0] a;
        logic g;
        rreg(`ADDR_CONFIG, 8'h00);
        rreg(8'h40, 8'h00);
        wreg(`ADDR_INDEX, 8'h01);
        wreg(`ADDR_CONFIG, 8'hff);
        rreg(`ADDR_CONFIG, 8'hec);
        chk({2'h0, fifo_split, out_enabled}, 8'h0f);
        wreg(`ADDR_CONFIG, 8'h20);
        repeat (2) @(negedge clock);
        chk({2'h0, in_enabled, out_enabled}, 8'h0e);
        wreg(`ADDR_CONFIG, 8'h00);
        host.xfer(2'h1, `HS_ACK, a, g);
        chk({7'h0, g}, 8'h00);
        wreg(`ADDR_CONFIG, 8'h04);
        repeat (2) @(negedge clock);
        chk({5'h0, in_enabled}, 8'h01);
    endtask
    task automatic s_bulk();
        wreg(`ADDR_CONFIG, 8'h20);
        wreg(`ADDR_IRQ_ENABLE, 8'h01);
        load(2, 8'h01);
        rreg(`ADDR_CTRL_STATUS, 8'h03);
        tok(`HS_ACK, `ANS_DATA);
        rreg(`ADDR_CTRL_STATUS, 8'h00);
        rreg(`ADDR_IRQ_STATUS, 8'h01);
        chk({7'h0, irq}, 8'h01);
        rreg(`ADDR_TOGGLE, 8'h01);
        load(0, 8'h01);
        tok(`HS_NAK, `ANS_ZLP);
        chk({7'h0, host.last_toggle}, 8'h01);
        rreg(`ADDR_TOGGLE, 8'h01);
        tok(`HS_ACK, `ANS_NAK);
        // writing one to the underrun bit keeps the flag
        load(1, 8'h05);
        tok(`HS_ACK, `ANS_DATA);
        rreg(`ADDR_CTRL_STATUS, 8'h04);
        wreg(`ADDR_CONFIG, 8'h28);
        load(0, 8'h01);
        tok(`HS_NAK, `ANS_ZLP);
        rreg(`ADDR_TOGGLE, 8'h01);
        wreg(`ADDR_CTRL_STATUS, 8'hc0);
        rreg(`ADDR_TOGGLE, 8'h00);
        rreg(`ADDR_CTRL_STATUS, 8'h00);
        wreg(`ADDR_IRQ_CLEAR, 8'h01);
        rreg(`ADDR_IRQ_STATUS, 8'h00);
        chk({7'h0, irq}, 8'h00);
    endtask
    task automatic s_stall_flush();
        load(1, 8'h11);
        tok(`HS_ACK, `ANS_STALL);
        rreg(`ADDR_CTRL_STATUS, 8'h30);
        rreg(`ADDR_IRQ_STATUS, 8'h01);
        tok(`HS_ACK, `ANS_STALL);
        wreg(`ADDR_CTRL_STATUS, 8'h00);
        wreg(`ADDR_IRQ_CLEAR, 8'h01);
        load(1, 8'h01);
        wreg(`ADDR_CTRL_STATUS, 8'h08);
        rreg(`ADDR_CTRL_STATUS, 8'h00);
        rreg(`ADDR_IRQ_STATUS, 8'h01);
        tok(`HS_ACK, `ANS_NAK);
    endtask
    task automatic s_dbuf_iso();
        wreg(`ADDR_CONFIG, 8'ha0);
        wreg(`ADDR_CTRL_STATUS, 8'h00);
        wreg(`ADDR_IRQ_CLEAR, 8'h01);
        load(1, 8'h01);
        rreg(`ADDR_CTRL_STATUS, 8'h02);
        load(1, 8'h01);
        rreg(`ADDR_IRQ_STATUS, 8'h00);
        tok(`HS_ACK, `ANS_DATA);
        tok(`HS_ACK, `ANS_DATA);
        rreg(`ADDR_CTRL_STATUS, 8'h00);
        wreg(`ADDR_CONFIG, 8'h60);
        tok(`HS_ACK, `ANS_ZLP);
        frame();
        wreg(`ADDR_INDEX, 8'h02);
        rreg(`ADDR_CTRL_STATUS, 8'h00);
        wreg(`ADDR_INDEX, 8'h01);
        rreg(`ADDR_CTRL_STATUS, 8'h04);
        load(1, 8'h11);
        tok(`HS_ACK, `ANS_DATA);
        frame();
        wreg(`ADDR_CTRL_STATUS, 8'h00);
        isochronous_update <= 1'b1;
        load(1, 8'h01);
        rreg(`ADDR_CTRL_STATUS, 8'h02);
        tok(`HS_ACK, `ANS_ZLP);
        frame();
        tok(`HS_ACK, `ANS_DATA);
    endtask
    // ============================================================
    // run control
    task automatic results();
        $display("checks=%0d errors=%0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(posedge clock);
        nrst <= 1'b1;
        s_config();
        s_bulk();
        s_stall_flush();
        s_dbuf_iso();
        results();
    end
    // the whole run needs well under 1000 cycles
    initial
    begin
        #400000;
        fail_count++;
        results();
    end
endmodule // tb_usb_in_endpoint_control
bind usb_in_endpoint_control usb_in_ep_monitor #(.NUM_EP(NUM_EP)) mon
    (.clock(clock), .nrst(nrst), .addr(addr), .wr(wr), .rd(rd),
    .rdata(rdata), .in_token(in_token), .token_ep(token_ep),
    .answer_valid(answer_valid), .in_enabled(in_enabled),
    .out_enabled(out_enabled), .fifo_split(fifo_split), .irq(irq));
